// File: gie_pkg.sv
// Purpose: constants for the guest exit unit
// Assumes: 64-bit control block fields, 8-bit event vectors
// Notes: cause codes and record layout are local encodings
package gie_pkg;
    // ------------------------------------------------------------
    // control block offsets
    // ------------------------------------------------------------
    localparam logic [11:0] GIE_OFS_NEXT_SEQ_IP = 12'h0c8;
    // ------------------------------------------------------------
    // pending event record layout
    // ------------------------------------------------------------
    localparam int GIE_REC_VEC_LSB = 0;
    localparam int GIE_REC_TYPE_LSB = 8;
    localparam int GIE_REC_EV_BIT = 11;
    localparam int GIE_REC_V_BIT = 31;
    localparam int GIE_REC_ERR_LSB = 32;
    localparam logic [63:0] GIE_REC_RESET = 64'h0;
    // event types held in the record
    localparam logic [2:0] GIE_TYPE_EXT_INT = 3'h0;
    localparam logic [2:0] GIE_TYPE_EXCEPTION = 3'h3;
    localparam logic [2:0] GIE_TYPE_SOFT_INT = 3'h4;
    // ------------------------------------------------------------
    // opcodes and vectors
    // ------------------------------------------------------------
    localparam logic [7:0] GIE_OP_VECTORED_SOFT_INT = 8'hcd;
    localparam logic [7:0] GIE_VEC_DOUBLE_FAULT = 8'h08;
    localparam logic [7:0] GIE_VEC_PAGE_FAULT = 8'h0e;
    localparam logic [7:0] GIE_VEC_DEBUG_TRAP = 8'h01;
    localparam logic [7:0] GIE_VEC_BREAKPOINT = 8'h03;
    localparam logic [7:0] GIE_VEC_OVERFLOW = 8'h04;
    localparam logic [7:0] GIE_VEC_BOUNDS = 8'h05;
    // vectors whose own status registers update even when intercepted
    localparam logic [31:0] GIE_SPEC_REG_MASK = 32'h0000_4002;
    // contributory exception vectors 0, 10..13
    localparam logic [31:0] GIE_CONTRIB_MASK = 32'h0000_3c01;
    // ------------------------------------------------------------
    // exit cause codes
    // ------------------------------------------------------------
    localparam logic [63:0] GIE_CAUSE_EXC_BASE = 64'h40;
    localparam logic [63:0] GIE_CAUSE_EXT_INT = 64'h60;
    localparam logic [63:0] GIE_CAUSE_VIRT_INT = 64'h64;
    localparam logic [63:0] GIE_CAUSE_SHUTDOWN = 64'h7f;
    localparam logic [63:0] GIE_ZERO64 = 64'h0;
    // combination results
    typedef enum {GIE_CMB_PLAIN, GIE_CMB_DF, GIE_CMB_SHUTDOWN} gie_cmb_e;
    // delivery state
    typedef enum {GIE_DLV_IDLE, GIE_DLV_ACTIVE} gie_dlv_e;
endpackage : gie_pkg

// File: gie_exit_unit.sv
// Purpose: decide guest intercepts and record exit information
// Assumes: at most one of exception, interrupt or instruction check per cycle
// Notes: exit fields appear one cycle after the deciding event
// What this block does
// - exception intercepts precede double-fault combining and delivery.
// - intercepted external or virtual interrupts stay pending.
// - instruction intercepts before commit, after simple checks (early ones before them), before memory faults.
// - breakpoints and pending data breakpoint traps precede instruction intercepts.
// - every exit writes a cause code, some causes two details.
// - state saved at trigger; traps save the post-instruction pointer.
// - instruction, msr/io, breakpoint/overflow/bounds exits save next pointer.
// - all other exits zero the next pointer.
// - next pointer is the sequential successor, never a branch target.
// - a capability bit advertises next pointer saving.
// - every exit records whether table delivery was in progress.
// - debug trap, breakpoint, overflow opcodes are exceptions; only vectored is soft.
// - bit 11 set when the interrupted exception pushes an error code.
// - bit 31 set when the intercept hit during table delivery.
// - bits 63:32 carry the error code when bit 11 is set.
// - nested exceptions: record holds all but the intercepted one.
// - exit if intercepted, combine, then exit on double fault or shutdown.
// - delivered event is recorded before table delivery.
// - successful delivery clears record valid and dispatches the handler.
// - cause and details describe the intercepted exception, record the earlier.
// - exception-specific registers update even when intercepted.
`timescale 1ns/100ps
`default_nettype none
module gie_exit_unit (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic instr_valid_in,
    input wire logic [63:0] instr_ip_in,
    input wire logic [3:0] instr_len_in,
    input wire logic instr_bkpt_in,
    input wire logic data_bkpt_pend_in,
    input wire logic instr_simple_exc_in,
    input wire logic instr_icpt_early_in,
    input wire logic instr_icpt_hit_in,
    input wire logic instr_is_msr_io_in,
    input wire logic [63:0] instr_cause_in,
    input wire logic [63:0] instr_detail_one_in,
    input wire logic [63:0] instr_detail_two_in,
    input wire logic exc_valid_in,
    input wire logic [7:0] exc_vector_in,
    input wire logic exc_is_trap_in,
    input wire logic exc_has_err_in,
    input wire logic [31:0] exc_err_code_in,
    input wire logic exc_from_opcode_in,
    input wire logic [7:0] exc_opcode_in,
    input wire logic [63:0] exc_ip_in,
    input wire logic [3:0] exc_len_in,
    input wire logic [63:0] exc_detail_one_in,
    input wire logic [63:0] exc_detail_two_in,
    input wire logic [31:0] exc_icpt_mask_in,
    input wire logic df_icpt_in,
    input wire logic shutdown_icpt_in,
    input wire logic intr_valid_in,
    input wire logic intr_virtual_in,
    input wire logic [7:0] intr_vector_in,
    input wire logic intr_icpt_in,
    input wire logic deliver_done_in,
    output logic commit_out,
    output logic debug_raise_out,
    output logic intr_ack_out,
    output logic deliver_start_out,
    output logic dispatch_out,
    output logic shutdown_out,
    output logic spec_reg_update_out,
    output logic next_ip_save_support_out,
    output logic exit_out,
    output logic [63:0] exit_cause_code_out,
    output logic [63:0] exit_detail_one_out,
    output logic [63:0] exit_detail_two_out,
    output logic [63:0] next_seq_ip_out,
    output logic [63:0] saved_guest_ip_out,
    output logic [63:0] pending_event_record_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_mask(input logic [31:0] mask, input logic [7:0] vec);
        in_mask = (vec[7:5] == 3'h0) && mask[vec[4:0]];
    endfunction : in_mask

    function automatic logic [63:0] next_ip(input logic [63:0] ip, input logic [3:0] len);
        next_ip = ip + {60'h0, len};
    endfunction : next_ip

    logic exit_reg;
    logic [63:0] cause_reg;
    logic [63:0] detail_one_reg;
    logic [63:0] detail_two_reg;
    logic [63:0] nsip_reg;
    logic [63:0] guest_ip_reg;
    logic [63:0] record_reg;
    gie_pkg::gie_dlv_e dlv_reg;

    logic rec_valid;
    logic [7:0] rec_vec;
    logic [2:0] exc_type;
    logic exc_icpt;
    gie_pkg::gie_cmb_e cmb;
    logic exc_exit;
    logic exc_deliver;
    logic intr_exit;
    logic instr_gate;
    logic instr_exit;
    logic any_exit;

    assign rec_valid = record_reg[gie_pkg::GIE_REC_V_BIT];
    assign rec_vec = record_reg[7:0];

    // ------------------------------------------------------------
    // exception path: intercept check, combine, delivery
    // ------------------------------------------------------------
    always_comb begin
        // only the vectored opcode is a software interrupt
        if (exc_from_opcode_in && exc_opcode_in == gie_pkg::GIE_OP_VECTORED_SOFT_INT) begin
            exc_type = gie_pkg::GIE_TYPE_SOFT_INT;
        end else begin
            exc_type = gie_pkg::GIE_TYPE_EXCEPTION;
        end
        // soft interrupts through low vectors are not exception intercepts
        exc_icpt = exc_valid_in && exc_type == gie_pkg::GIE_TYPE_EXCEPTION
                   && in_mask(exc_icpt_mask_in, exc_vector_in);
        cmb = gie_pkg::GIE_CMB_PLAIN;
        if (rec_valid && record_reg[10:8] == gie_pkg::GIE_TYPE_EXCEPTION) begin
            if (rec_vec == gie_pkg::GIE_VEC_DOUBLE_FAULT) begin
                cmb = gie_pkg::GIE_CMB_SHUTDOWN;
            end else if (in_mask(gie_pkg::GIE_CONTRIB_MASK, exc_vector_in)
                         && in_mask(gie_pkg::GIE_CONTRIB_MASK, rec_vec)) begin
                cmb = gie_pkg::GIE_CMB_DF;
            end else if (rec_vec == gie_pkg::GIE_VEC_PAGE_FAULT
                         && (exc_vector_in == gie_pkg::GIE_VEC_PAGE_FAULT
                             || in_mask(gie_pkg::GIE_CONTRIB_MASK, exc_vector_in))) begin
                cmb = gie_pkg::GIE_CMB_DF;
            end
        end
        exc_exit = exc_icpt
                   || (exc_valid_in && cmb == gie_pkg::GIE_CMB_DF && df_icpt_in)
                   || (exc_valid_in && cmb == gie_pkg::GIE_CMB_SHUTDOWN && shutdown_icpt_in);
        exc_deliver = exc_valid_in && !exc_exit && cmb != gie_pkg::GIE_CMB_SHUTDOWN;
    end

    assign shutdown_out = exc_valid_in && !exc_icpt
                          && cmb == gie_pkg::GIE_CMB_SHUTDOWN && !shutdown_icpt_in;
    assign spec_reg_update_out = exc_valid_in
                                 && in_mask(gie_pkg::GIE_SPEC_REG_MASK, exc_vector_in);

    // ------------------------------------------------------------
    // interrupts and instruction checks
    // ------------------------------------------------------------
    assign intr_exit = !exc_valid_in && intr_valid_in && intr_icpt_in;
    // never acknowledged while intercepted, so it stays pending
    assign intr_ack_out = !exc_valid_in && intr_valid_in && !intr_icpt_in;
    assign instr_gate = !exc_valid_in && !intr_valid_in && instr_valid_in;
    // breakpoints first; simple faults beat ordinary intercepts but not early ones
    assign debug_raise_out = instr_gate && (instr_bkpt_in || data_bkpt_pend_in);
    assign instr_exit = instr_gate && !instr_bkpt_in && !data_bkpt_pend_in
                        && instr_icpt_hit_in
                        && (instr_icpt_early_in || !instr_simple_exc_in);
    assign commit_out = instr_gate && !instr_bkpt_in && !data_bkpt_pend_in
                        && !instr_simple_exc_in && !instr_icpt_hit_in;
    assign any_exit = exc_exit || intr_exit || instr_exit;
    assign deliver_start_out = exc_deliver || intr_ack_out;
    assign dispatch_out = deliver_done_in && dlv_reg == gie_pkg::GIE_DLV_ACTIVE;
    assign next_ip_save_support_out = 1'b1;

    // ------------------------------------------------------------
    // exit fields
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            exit_reg <= 1'b0;
            cause_reg <= gie_pkg::GIE_ZERO64;
            detail_one_reg <= gie_pkg::GIE_ZERO64;
            detail_two_reg <= gie_pkg::GIE_ZERO64;
            nsip_reg <= gie_pkg::GIE_ZERO64;
            guest_ip_reg <= gie_pkg::GIE_ZERO64;
        end else begin
            exit_reg <= any_exit;
            if (exc_exit) begin
                // cause describes the intercepted event, record the earlier one
                if (exc_icpt) begin
                    cause_reg <= gie_pkg::GIE_CAUSE_EXC_BASE + {56'h0, exc_vector_in};
                end else if (cmb == gie_pkg::GIE_CMB_DF) begin
                    cause_reg <= gie_pkg::GIE_CAUSE_EXC_BASE
                                 + {56'h0, gie_pkg::GIE_VEC_DOUBLE_FAULT};
                end else begin
                    cause_reg <= gie_pkg::GIE_CAUSE_SHUTDOWN;
                end
                detail_one_reg <= exc_detail_one_in;
                detail_two_reg <= exc_detail_two_in;
                // traps report the pointer past the instruction
                guest_ip_reg <= exc_is_trap_in ? next_ip(exc_ip_in, exc_len_in)
                                               : exc_ip_in;
                if (exc_icpt && (exc_vector_in == gie_pkg::GIE_VEC_BREAKPOINT
                                 || exc_vector_in == gie_pkg::GIE_VEC_OVERFLOW
                                 || exc_vector_in == gie_pkg::GIE_VEC_BOUNDS)) begin
                    nsip_reg <= next_ip(exc_ip_in, exc_len_in);
                end else begin
                    nsip_reg <= gie_pkg::GIE_ZERO64;
                end
            end else if (intr_exit) begin
                cause_reg <= intr_virtual_in ? gie_pkg::GIE_CAUSE_VIRT_INT
                                             : gie_pkg::GIE_CAUSE_EXT_INT;
                detail_one_reg <= gie_pkg::GIE_ZERO64;
                detail_two_reg <= gie_pkg::GIE_ZERO64;
                guest_ip_reg <= instr_ip_in;
                nsip_reg <= gie_pkg::GIE_ZERO64;
            end else if (instr_exit) begin
                cause_reg <= instr_cause_in;
                detail_one_reg <= instr_detail_one_in;
                detail_two_reg <= instr_detail_two_in;
                // nothing committed, so the guest pointer stays put
                guest_ip_reg <= instr_ip_in;
                // sequential even for control transfers
                nsip_reg <= next_ip(instr_ip_in, instr_len_in);
            end
        end
    end

    // ------------------------------------------------------------
    // pending event record and delivery state
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            record_reg <= gie_pkg::GIE_REC_RESET;
            dlv_reg <= gie_pkg::GIE_DLV_IDLE;
        end else if (exc_deliver) begin
            // a new delivery wins over a same-cycle completion
            record_reg[7:0] <= (cmb == gie_pkg::GIE_CMB_DF) ? gie_pkg::GIE_VEC_DOUBLE_FAULT
                                                          : exc_vector_in;
            record_reg[10:8] <= exc_type;
            record_reg[gie_pkg::GIE_REC_EV_BIT] <= exc_has_err_in
                                                   || cmb == gie_pkg::GIE_CMB_DF;
            record_reg[30:12] <= 19'h0;
            record_reg[gie_pkg::GIE_REC_V_BIT] <= 1'b1;
            record_reg[63:32] <= (cmb == gie_pkg::GIE_CMB_DF) ? 32'h0
                                                            : exc_err_code_in;
            dlv_reg <= gie_pkg::GIE_DLV_ACTIVE;
        end else if (intr_ack_out) begin
            record_reg <= {32'h0, 1'b1, 19'h0, 1'b0, gie_pkg::GIE_TYPE_EXT_INT,
                           intr_vector_in};
            dlv_reg <= gie_pkg::GIE_DLV_ACTIVE;
        end else if (dispatch_out || any_exit) begin
            // an exit ends the guest's delivery; record keeps its valid state unless a same-cycle dispatch clears it
            if (dispatch_out) begin
                record_reg[gie_pkg::GIE_REC_V_BIT] <= 1'b0;
            end
            dlv_reg <= gie_pkg::GIE_DLV_IDLE;
        end
    end

    assign exit_out = exit_reg;
    assign exit_cause_code_out = cause_reg;
    assign exit_detail_one_out = detail_one_reg;
    assign exit_detail_two_out = detail_two_reg;
    assign next_seq_ip_out = nsip_reg;
    assign saved_guest_ip_out = guest_ip_reg;
    // valid bit at exit time shows delivery in progress
    assign pending_event_record_out = record_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_exc_icpt_no_deliver;
        @(posedge clock_in) disable iff (!rstn_in)
        exc_icpt |-> !deliver_start_out && !shutdown_out;
    endproperty
    a_exc_icpt_no_deliver: assert property (p_exc_icpt_no_deliver)
        else $error("intercepted exception delivered");

    property p_intr_pending;
        @(posedge clock_in) disable iff (!rstn_in)
        intr_exit |-> !intr_ack_out ##1 exit_out;
    endproperty
    a_intr_pending: assert property (p_intr_pending)
        else $error("intercepted interrupt consumed");

    property p_instr_no_commit;
        @(posedge clock_in) disable iff (!rstn_in)
        instr_exit |-> !commit_out ##1 (exit_out && saved_guest_ip_out == $past(instr_ip_in));
    endproperty
    a_instr_no_commit: assert property (p_instr_no_commit)
        else $error("instruction exit committed");

    property p_bkpt_first;
        @(posedge clock_in) disable iff (!rstn_in)
        (instr_gate && (instr_bkpt_in || data_bkpt_pend_in)) |-> !instr_exit && debug_raise_out;
    endproperty
    a_bkpt_first: assert property (p_bkpt_first)
        else $error("intercept beat breakpoint");

    property p_instr_nsip;
        @(posedge clock_in) disable iff (!rstn_in)
        instr_exit |=> next_seq_ip_out == $past(instr_ip_in) + {60'h0, $past(instr_len_in)};
    endproperty
    a_instr_nsip: assert property (p_instr_nsip)
        else $error("bad next pointer");

    property p_other_nsip_zero;
        @(posedge clock_in) disable iff (!rstn_in)
        intr_exit |=> next_seq_ip_out == 64'h0;
    endproperty
    a_other_nsip_zero: assert property (p_other_nsip_zero)
        else $error("next pointer not zero");

    property p_trap_ip;
        @(posedge clock_in) disable iff (!rstn_in)
        (exc_exit && exc_is_trap_in) |=>
            saved_guest_ip_out == $past(exc_ip_in) + {60'h0, $past(exc_len_in)};
    endproperty
    a_trap_ip: assert property (p_trap_ip)
        else $error("bad trap pointer");

    property p_record_on_deliver;
        @(posedge clock_in) disable iff (!rstn_in)
        exc_deliver |=> pending_event_record_out[31]
            && pending_event_record_out[11] == ($past(exc_has_err_in) || $past(cmb) == gie_pkg::GIE_CMB_DF);
    endproperty
    a_record_on_deliver: assert property (p_record_on_deliver)
        else $error("record not written");

    property p_dispatch_clears;
        @(posedge clock_in) disable iff (!rstn_in)
        (dispatch_out && !deliver_start_out) |=> !pending_event_record_out[31];
    endproperty
    a_dispatch_clears: assert property (p_dispatch_clears)
        else $error("record valid not cleared");

    property p_exc_cause;
        @(posedge clock_in) disable iff (!rstn_in)
        exc_icpt |=> exit_cause_code_out == 64'h40 + {56'h0, $past(exc_vector_in)}
            && $stable(pending_event_record_out);
    endproperty
    a_exc_cause: assert property (p_exc_cause)
        else $error("bad exception exit");

    property p_soft_type;
        @(posedge clock_in) disable iff (!rstn_in)
        (exc_deliver && exc_from_opcode_in && exc_opcode_in != 8'hcd) |=>
            pending_event_record_out[10:8] == 3'h3;
    endproperty
    a_soft_type: assert property (p_soft_type)
        else $error("opcode event not exception");
endmodule : gie_exit_unit
`default_nettype wire

// File: gie_hv_model.sv
// Purpose: hypervisor model reading exit fields
// Assumes: fields valid while exit_in is high
// Notes: keeps only the last exit
`timescale 1ns/100ps
`default_nettype none
module gie_hv_model (
    input wire logic clock_in,
    input wire logic exit_in,
    input wire logic [63:0] cause_in,
    input wire logic [63:0] record_in,
    output logic [63:0] last_cause_out,
    output logic reflect_df_out
);
    // ------------------------------------------------------------
    // capture and merge
    // ------------------------------------------------------------
    // a valid prior exception plus the reflected one escalates
    always_ff @(posedge clock_in) begin
        if (exit_in) begin
            last_cause_out <= cause_in;
            reflect_df_out <= record_in[31] && (record_in[10:8] == gie_pkg::GIE_TYPE_EXCEPTION);
        end
    end
endmodule : gie_hv_model
`default_nettype wire

// File: test_guest_intercept_exit_info.sv
// Purpose: bench for the guest exit unit
// Assumes: exit fields valid one cycle after the event
// Notes: fixed scenario order
`timescale 1ns/100ps
`default_nettype none
module test_guest_intercept_exit_info;
    logic clock_in, rstn_in, instr_valid_in, instr_bkpt_in, data_bkpt_pend_in, instr_is_msr_io_in;
    logic instr_simple_exc_in, instr_icpt_early_in, instr_icpt_hit_in, exc_valid_in, exc_is_trap_in;
    logic exc_has_err_in, exc_from_opcode_in, df_icpt_in, shutdown_icpt_in, intr_valid_in;
    logic intr_virtual_in, intr_icpt_in, deliver_done_in, hv_reflect_df;
    logic [3:0] instr_len_in, exc_len_in;
    logic [7:0] exc_vector_in, exc_opcode_in, intr_vector_in;
    logic [31:0] exc_err_code_in, exc_icpt_mask_in;
    logic [63:0] instr_ip_in, instr_cause_in, instr_detail_one_in, instr_detail_two_in;
    logic [63:0] exc_ip_in, exc_detail_one_in, exc_detail_two_in, hv_cause;
    logic commit_out, debug_raise_out, intr_ack_out, deliver_start_out, dispatch_out, exit_out;
    logic shutdown_out, spec_reg_update_out, next_ip_save_support_out;
    logic [63:0] exit_cause_code_out, exit_detail_one_out, exit_detail_two_out;
    logic [63:0] next_seq_ip_out, saved_guest_ip_out, pending_event_record_out;
    int fail_count = 0;
    int checks = 0;
    gie_exit_unit i_dut (.clock_in, .rstn_in, .instr_valid_in, .instr_ip_in, .instr_len_in,
        .instr_bkpt_in, .data_bkpt_pend_in, .instr_simple_exc_in, .instr_icpt_early_in,
        .instr_icpt_hit_in, .instr_is_msr_io_in, .instr_cause_in, .instr_detail_one_in,
        .instr_detail_two_in, .exc_valid_in, .exc_vector_in, .exc_is_trap_in, .exc_has_err_in,
        .exc_err_code_in, .exc_from_opcode_in, .exc_opcode_in, .exc_ip_in, .exc_len_in,
        .exc_detail_one_in, .exc_detail_two_in, .exc_icpt_mask_in, .df_icpt_in,
        .shutdown_icpt_in, .intr_valid_in, .intr_virtual_in, .intr_vector_in, .intr_icpt_in,
        .deliver_done_in, .commit_out, .debug_raise_out, .intr_ack_out, .deliver_start_out,
        .dispatch_out, .shutdown_out, .spec_reg_update_out, .next_ip_save_support_out,
        .exit_out, .exit_cause_code_out, .exit_detail_one_out, .exit_detail_two_out,
        .next_seq_ip_out, .saved_guest_ip_out, .pending_event_record_out);
    gie_hv_model i_hv (.clock_in, .exit_in(exit_out), .cause_in(exit_cause_code_out),
        .record_in(pending_event_record_out), .last_cause_out(hv_cause),
        .reflect_df_out(hv_reflect_df));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step;
        @(posedge clock_in);
        #1;
    endtask : step
    task automatic idle;
        step();
        {exc_valid_in, intr_valid_in, instr_valid_in, deliver_done_in} = 4'h0;
        {instr_bkpt_in, data_bkpt_pend_in, exc_from_opcode_in, exc_is_trap_in} = 4'h0;
    endtask : idle
    // vectors 13 and 14 push an error code
    task automatic raise(input logic [7:0] v, input logic [31:0] m, input logic [7:0] op);
        step();
        exc_valid_in = 1'b1;
        exc_vector_in = v;
        exc_icpt_mask_in = m;
        exc_has_err_in = (v == 8'h0d || v == 8'h0e);
        exc_from_opcode_in = (op != 8'h00);
        exc_opcode_in = op;
        #1;
    endtask : raise
    function automatic logic [63:0] rec(input logic [7:0] v, input logic [2:0] t,
            input logic ev, input logic [31:0] e);
        rec = {e, 20'h80000, ev, t, v};
    endfunction : rec
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_instr;
        step();
        {instr_valid_in, instr_icpt_hit_in, instr_simple_exc_in, instr_icpt_early_in} = 4'hf;
        #1 chk(commit_out, 64'h0);
        idle();
        chk(exit_out, 64'h1);
        chk(exit_cause_code_out, 64'h72);
        chk(exit_detail_one_out, 64'h11);
        chk(next_seq_ip_out, 64'h1003);
        chk(saved_guest_ip_out, 64'h1000);
        chk(pending_event_record_out[31], 64'h0);
        {instr_valid_in, instr_icpt_early_in} = 2'h2;
        step();
        chk(exit_out, 64'h0);
        for (int i = 0; i < 2; i++) begin
            {instr_valid_in, instr_simple_exc_in, instr_bkpt_in, data_bkpt_pend_in} = {2'h2, i == 0, i == 1};
            #1 chk(debug_raise_out, 64'h1);
            idle();
            chk(exit_out, 64'h0);
        end
        instr_icpt_hit_in = 1'b0;
        instr_valid_in = 1'b1;
        #1 chk(commit_out, 64'h1);
        idle();
        $display("instr test done");
    endtask : t_instr
    task automatic t_intr;
        for (int v = 0; v < 2; v++) begin
            {intr_valid_in, intr_virtual_in, intr_icpt_in, instr_valid_in} = {1'b1, v == 1, 2'h3};
            #1 chk(intr_ack_out, 64'h0);
            idle();
            chk(exit_cause_code_out, v ? 64'h64 : 64'h60);
            chk(next_seq_ip_out, 64'h0);
        end
        {intr_valid_in, intr_icpt_in} = 2'h2;
        #1 chk(intr_ack_out, 64'h1);
        idle();
        chk(pending_event_record_out[31:0], 64'h8000_0020);
        deliver_done_in = 1'b1;
        idle();
        $display("intr test done");
    endtask : t_intr
    task automatic t_exc;
        raise(8'h0d, 32'h0, 8'h00);
        chk(deliver_start_out, 64'h1);
        idle();
        chk(pending_event_record_out, rec(8'h0d, 3'h3, 1'b1, 32'h10));
        raise(8'h0e, 32'h4000, 8'h00);
        chk(deliver_start_out, 64'h0);
        chk(spec_reg_update_out, 64'h1);
        idle();
        chk(exit_cause_code_out, 64'h4e);
        chk(exit_detail_one_out, 64'h22);
        chk(exit_detail_two_out, 64'h33);
        chk(pending_event_record_out, rec(8'h0d, 3'h3, 1'b1, 32'h10));
        chk(next_seq_ip_out, 64'h0);
        step();
        chk(hv_reflect_df, 64'h1);
        chk(hv_cause, 64'h4e);
        df_icpt_in = 1'b1;
        raise(8'h0d, 32'h0, 8'h00);
        idle();
        chk(exit_cause_code_out, 64'h48);
        df_icpt_in = 1'b0;
        raise(8'h0d, 32'h0, 8'h00);
        idle();
        chk(pending_event_record_out, rec(8'h08, 3'h3, 1'b1, 32'h0));
        shutdown_icpt_in = 1'b1;
        raise(8'h0d, 32'h0, 8'h00);
        chk(shutdown_out, 64'h0);
        idle();
        chk(exit_cause_code_out, 64'h7f);
        intr_valid_in = 1'b1;
        idle();
        deliver_done_in = 1'b1;
        #1 chk(dispatch_out, 64'h1);
        idle();
        chk(pending_event_record_out[31], 64'h0);
        $display("exc test done");
    endtask : t_exc
    task automatic t_op;
        raise(8'h03, 32'h0, 8'hcc);
        idle();
        chk(pending_event_record_out[10:8], {61'h0, gie_pkg::GIE_TYPE_EXCEPTION});
        deliver_done_in = 1'b1;
        raise(8'h03, 32'h8, 8'hcd);
        idle();
        chk(pending_event_record_out[10:8], {61'h0, gie_pkg::GIE_TYPE_SOFT_INT});
        {deliver_done_in, exc_is_trap_in} = 2'h3;
        raise(8'h03, 32'h8, 8'hcc);
        idle();
        chk(exit_cause_code_out, 64'h43);
        chk(next_seq_ip_out, 64'h2002);
        chk(saved_guest_ip_out, 64'h2002);
        chk(next_ip_save_support_out, 64'h1);
        $display("op test done");
    endtask : t_op
    task automatic results;
        $display("checks=%0d failures=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        {rstn_in, instr_valid_in, instr_bkpt_in, data_bkpt_pend_in, instr_is_msr_io_in} = 5'h0;
        {instr_simple_exc_in, instr_icpt_early_in, instr_icpt_hit_in, exc_valid_in} = 4'h0;
        {exc_is_trap_in, exc_has_err_in, exc_from_opcode_in, df_icpt_in, shutdown_icpt_in} = 5'h0;
        {intr_valid_in, intr_virtual_in, intr_icpt_in, deliver_done_in} = 4'h0;
        {exc_vector_in, exc_opcode_in, exc_icpt_mask_in, instr_detail_two_in} = '0;
        {exc_detail_two_in, instr_ip_in, instr_len_in} = {64'h33, 64'h1000, 4'h3};
        {instr_cause_in, instr_detail_one_in, exc_ip_in} = {64'h72, 64'h11, 64'h2000};
        {exc_len_in, exc_err_code_in, exc_detail_one_in} = {4'h2, 32'h10, 64'h22};
        intr_vector_in = 8'h20;
        repeat (2) @(posedge clock_in);
        #1 rstn_in = 1'b1;
        chk(pending_event_record_out, gie_pkg::GIE_REC_RESET);
        t_instr();
        t_intr();
        t_exc();
        t_op();
        results();
    end
endmodule : test_guest_intercept_exit_info
`default_nettype wire
